// *** design/stp_timer_prescaler.sv ***
// Shared prescaler and source select for two timers, with an AHB-Lite register slave.
// Assumes one ref_clk domain, word accesses, and count pins asynchronous to ref_clk.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "stp_consts.svh"

// Functional notes
// - Each timer has its own source select.
// - Select 1 ticks every system clock.
// - Taps at divide by 8, 64, 256, 1024.
// - Prescaler runs regardless of any select.
// - First prescaled tick within 1 to N+1.
// - Prescaler reset restarts taps for both timers.
// - Count pin sampled each clock, then edge-detected.
// - Clock-high latch followed by rising-edge flops.
// - One tick per rising (7) or falling (6) edge.
// - Pin edge to count takes 2.5 to 3.5 cycles.
// - Pin ticks bypass the prescaler divider.
// - Sync hold mode keeps written reset bits.
// - Clearing hold mode clears both reset bits.
// - Prescaler reset bit self-clears unless holding.
// - Pin counts even when driven as output.
module stp_timer_prescaler (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic countPinA,
	input wire logic countPinB,
	output logic timerATick,
	output logic timerBTick,
	output logic asyncPrescalerReset
);
	typedef struct packed {
		logic syncHoldMode;
		logic asyncReset;
		logic syncReset;
		logic [`STP_SEL_W-1:0] selA;
		logic [`STP_SEL_W-1:0] selB;
		logic dataWrite;
		logic [5:0] dataAddr;
		logic [31:0] rdata;
		logic ready;
		logic tickA;
		logic tickB;
	} stp_top_s;

	stp_top_s r, n;
	logic [`STP_CNT_W-1:0] prescCount;
	logic [`STP_TAP_N-1:0] tap;
	logic levelA;
	logic levelB;
	logic riseA;
	logic riseB;
	logic fallA;
	logic fallB;
	logic addrTaken;
	logic gtcWrite;

	// The shared counter is never told about the selects, so a select change cannot disturb it.
	stp_prescale_counter u_presc (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.holdReset(r.syncReset),
		.count(prescCount),
		.tap(tap)
	);

	// Pin direction is not looked at, so software driving the pin still counts.
	stp_pin_sync u_sync_a (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.countPin(countPinA),
		.pinLevel(levelA),
		.riseTick(riseA),
		.fallTick(fallA)
	);

	stp_pin_sync u_sync_b (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.countPin(countPinB),
		.pinLevel(levelB),
		.riseTick(riseB),
		.fallTick(fallB)
	);

	// One selector serves both timers, each with its own select field.
	function automatic logic stp_pick(
		input logic [`STP_SEL_W-1:0] sel,
		input logic [`STP_TAP_N-1:0] taps,
		input logic rise,
		input logic fall
	);
		logic hit;
		hit = 1'b0;
		case (stp_pkg::stp_src_e'(sel))
			stp_pkg::STP_SRC_OFF: hit = 1'b0;
			stp_pkg::STP_SRC_CLK: hit = 1'b1;
			stp_pkg::STP_SRC_DIV8: hit = taps[0];
			stp_pkg::STP_SRC_DIV64: hit = taps[1];
			stp_pkg::STP_SRC_DIV256: hit = taps[2];
			stp_pkg::STP_SRC_DIV1024: hit = taps[3];
			stp_pkg::STP_SRC_EXT_FALL: hit = fall;
			stp_pkg::STP_SRC_EXT_RISE: hit = rise;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Reads return the values that stand after this cycle's write, so a read right
	// behind a write to the same register sees the new contents.
	function automatic logic [31:0] stp_read(
		input logic [5:0] addr,
		input stp_top_s s,
		input logic [`STP_CNT_W-1:0] cnt,
		input logic pa,
		input logic pb
	);
		logic [31:0] d;
		d = 32'h0;
		case (addr)
			`STP_OFS_GTC: begin
				d[`STP_BIT_HOLD_MODE] = s.syncHoldMode;
				d[`STP_BIT_ASYNC_RST] = s.asyncReset;
				d[`STP_BIT_SYNC_RST] = s.syncReset;
			end
			`STP_OFS_SELA: d[`STP_SEL_W-1:0] = s.selA;
			`STP_OFS_SELB: d[`STP_SEL_W-1:0] = s.selB;
			`STP_OFS_STAT: begin
				d[`STP_CNT_W-1:0] = cnt;
				d[`STP_STAT_PINA] = pa;
				d[`STP_STAT_PINB] = pb;
			end
			default: d = 32'h0;
		endcase
		return d;
	endfunction

	assign addrTaken = hsel && hready && htrans[1];
	assign gtcWrite = r.dataWrite && (r.dataAddr == `STP_OFS_GTC);

	always_comb begin
		n = r;
		n.ready = 1'b1;

		// Without hold mode the reset bits last one cycle; this also clears them
		// when hold mode has just been switched off.
		if (!r.syncHoldMode) begin
			n.syncReset = 1'b0;
			n.asyncReset = 1'b0;
		end

		// Data phase of a write; a written one wins over the hardware clear.
		if (r.dataWrite) begin
			case (r.dataAddr)
				`STP_OFS_GTC: begin
					n.syncHoldMode = hwdata[`STP_BIT_HOLD_MODE];
					n.asyncReset = hwdata[`STP_BIT_ASYNC_RST];
					n.syncReset = hwdata[`STP_BIT_SYNC_RST];
				end
				`STP_OFS_SELA: n.selA = hwdata[`STP_SEL_W-1:0];
				`STP_OFS_SELB: n.selB = hwdata[`STP_SEL_W-1:0];
				default: n.selA = n.selA;
			endcase
		end

		// Address phase of the next transfer; unmapped reads return zero.
		n.dataWrite = addrTaken && hwrite;
		n.dataAddr = haddr[5:0];
		if (addrTaken && !hwrite) begin
			n.rdata = stp_read(haddr[5:0], n, prescCount, levelA, levelB);
		end else begin
			n.rdata = 32'h0;
		end

		// Ticks are enables one cycle wide; a held reset halts both timers.
		n.tickA = !r.syncReset && stp_pick(r.selA, tap, riseA, fallA);
		n.tickB = !r.syncReset && stp_pick(r.selB, tap, riseB, fallB);
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			r <= '0;
			r.ready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign hreadyout = r.ready;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;
	assign timerATick = r.tickA;
	assign timerBTick = r.tickB;
	assign asyncPrescalerReset = r.asyncReset;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_clk_direct;
		(r.selA == stp_pkg::STP_SRC_CLK && !r.syncReset) |=> timerATick;
	endproperty
	a_clk_direct: assert property (p_clk_direct) else $error("direct clock tick missing");

	property p_off_silent;
		(r.selB == stp_pkg::STP_SRC_OFF) |=> !timerBTick;
	endproperty
	a_off_silent: assert property (p_off_silent) else $error("tick with source off");

	property p_hold_silent;
		r.syncReset |=> !timerATick && !timerBTick;
	endproperty
	a_hold_silent: assert property (p_hold_silent) else $error("tick while held");

	property p_hold_kept;
		(r.syncReset && r.syncHoldMode && !gtcWrite) |=> r.syncReset;
	endproperty
	a_hold_kept: assert property (p_hold_kept) else $error("held reset lost");

	property p_self_clear;
		(r.syncReset && !r.syncHoldMode && !gtcWrite) |=> !r.syncReset;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("reset bit did not clear");

	sequence s_release_write;
		gtcWrite && !hwdata[`STP_BIT_HOLD_MODE] && !hwdata[`STP_BIT_SYNC_RST] &&
			!hwdata[`STP_BIT_ASYNC_RST];
	endsequence

	property p_release;
		s_release_write |=> !r.syncReset && !r.asyncReset && !r.syncHoldMode;
	endproperty
	a_release: assert property (p_release) else $error("release left resets set");

	property p_ext_rise;
		(r.selA == stp_pkg::STP_SRC_EXT_RISE && !r.syncReset && riseA) |=> timerATick;
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge lost");

	property p_ext_fall_only;
		(r.selB == stp_pkg::STP_SRC_EXT_FALL && !fallB) |=> !timerBTick;
	endproperty
	a_ext_fall_only: assert property (p_ext_fall_only) else $error("spurious pin tick");

	sequence s_sel8_new;
		r.selA == stp_pkg::STP_SRC_DIV8 && $past(r.selA) != stp_pkg::STP_SRC_DIV8 &&
			!r.syncReset;
	endsequence

	property p_first_div8;
		s_sel8_new |-> ##[1:9] (timerATick || r.selA != stp_pkg::STP_SRC_DIV8 || r.syncReset);
	endproperty
	a_first_div8: assert property (p_first_div8) else $error("divide by 8 too late");

	property p_clk_direct_b;
		(r.selB == stp_pkg::STP_SRC_CLK && !r.syncReset) |=> timerBTick;
	endproperty
	a_clk_direct_b: assert property (p_clk_direct_b) else $error("direct clock tick missing");

	property p_off_silent_a;
		(r.selA == stp_pkg::STP_SRC_OFF) |=> !timerATick;
	endproperty
	a_off_silent_a: assert property (p_off_silent_a) else $error("tick with source off");

	property p_ext_rise_b;
		(r.selB == stp_pkg::STP_SRC_EXT_RISE && !r.syncReset && riseB) |=> timerBTick;
	endproperty
	a_ext_rise_b: assert property (p_ext_rise_b) else $error("rising pin edge lost");

	property p_ext_fall_a;
		(r.selA == stp_pkg::STP_SRC_EXT_FALL && !r.syncReset && fallA) |=> timerATick;
	endproperty
	a_ext_fall_a: assert property (p_ext_fall_a) else $error("falling pin edge lost");

	property p_ext_fall_b;
		(r.selB == stp_pkg::STP_SRC_EXT_FALL && !r.syncReset && fallB) |=> timerBTick;
	endproperty
	a_ext_fall_b: assert property (p_ext_fall_b) else $error("falling pin edge lost");

	property p_ext_rise_only;
		(r.selA == stp_pkg::STP_SRC_EXT_RISE && !riseA) |=> !timerATick;
	endproperty
	a_ext_rise_only: assert property (p_ext_rise_only) else $error("spurious pin tick");

	property p_div64_tap;
		(r.selA == stp_pkg::STP_SRC_DIV64 && !r.syncReset) |=> (timerATick == $past(tap[1]));
	endproperty
	a_div64_tap: assert property (p_div64_tap) else $error("divide by 64 tick off");

	property p_div256_tap;
		(r.selB == stp_pkg::STP_SRC_DIV256 && !r.syncReset) |=> (timerBTick == $past(tap[2]));
	endproperty
	a_div256_tap: assert property (p_div256_tap) else $error("divide by 256 tick off");

	property p_div1024_tap;
		(r.selA == stp_pkg::STP_SRC_DIV1024 && !r.syncReset) |=> (timerATick == $past(tap[3]));
	endproperty
	a_div1024_tap: assert property (p_div1024_tap) else $error("divide by 1024 tick off");

	property p_sel_write_a;
		(r.dataWrite && r.dataAddr == `STP_OFS_SELA) |=> (r.selA == $past(hwdata[`STP_SEL_W-1:0]));
	endproperty
	a_sel_write_a: assert property (p_sel_write_a) else $error("select A not written");

	property p_sel_write_b;
		(r.dataWrite && r.dataAddr == `STP_OFS_SELB) |=> (r.selB == $past(hwdata[`STP_SEL_W-1:0]));
	endproperty
	a_sel_write_b: assert property (p_sel_write_b) else $error("select B not written");

	property p_sel_kept;
		!r.dataWrite |=> ($stable(r.selA) && $stable(r.selB));
	endproperty
	a_sel_kept: assert property (p_sel_kept) else $error("select changed without write");

	property p_async_kept;
		(r.asyncReset && r.syncHoldMode && !gtcWrite) |=> r.asyncReset;
	endproperty
	a_async_kept: assert property (p_async_kept) else $error("held async reset lost");

	property p_async_clear;
		(r.asyncReset && !r.syncHoldMode && !gtcWrite) |=> !r.asyncReset;
	endproperty
	a_async_clear: assert property (p_async_clear) else $error("async reset did not clear");

	// A held prescaler must restart from zero, or timers released together drift apart.
	sequence s_hold_end;
		r.syncReset ##1 !r.syncReset;
	endsequence

	property p_resume_zero;
		s_hold_end |-> (prescCount == '0) ##1 (prescCount == `STP_CNT_W'(1));
	endproperty
	a_resume_zero: assert property (p_resume_zero) else $error("prescaler not restarted");

	property p_shared_taps;
		(r.selA == r.selB && r.selA < stp_pkg::STP_SRC_EXT_FALL) |=> (timerATick == timerBTick);
	endproperty
	a_shared_taps: assert property (p_shared_taps) else $error("timers disagree on tap");

	property p_div8_single;
		(timerATick && r.selA == stp_pkg::STP_SRC_DIV8 && $past(r.selA) == stp_pkg::STP_SRC_DIV8)
			|=> !timerATick;
	endproperty
	a_div8_single: assert property (p_div8_single) else $error("divided tick too long");
endmodule // stp_timer_prescaler

// *** design/stp_consts.svh ***
// Named constants for the shared timer prescaler block.
// Assumes inclusion by bare name from the design files.
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH
`define STP_OFS_GTC 6'h00
`define STP_OFS_SELA 6'h04
`define STP_OFS_SELB 6'h08
`define STP_OFS_STAT 6'h0c
`define STP_BIT_HOLD_MODE 7
`define STP_BIT_ASYNC_RST 1
`define STP_BIT_SYNC_RST 0
`define STP_STAT_PINA 16
`define STP_STAT_PINB 17
`define STP_SEL_W 3
`define STP_CNT_W 10
`define STP_TAP_N 4
`define STP_TAP0_BITS 3
`define STP_TAP1_BITS 6
`define STP_TAP2_BITS 8
`define STP_TAP3_BITS 10
`endif

// *** design/stp_pkg.sv ***
// Types shared by the shared timer prescaler design files.
// Assumes stp_consts.svh is compiled alongside.
`include "stp_consts.svh"
package stp_pkg;
	typedef enum logic [2:0] {
		STP_SRC_OFF = 3'h0,
		STP_SRC_CLK = 3'h1,
		STP_SRC_DIV8 = 3'h2,
		STP_SRC_DIV64 = 3'h3,
		STP_SRC_DIV256 = 3'h4,
		STP_SRC_DIV1024 = 3'h5,
		STP_SRC_EXT_FALL = 3'h6,
		STP_SRC_EXT_RISE = 3'h7
	} stp_src_e;
	typedef struct packed {
		logic [`STP_CNT_W-1:0] count;
		logic [`STP_TAP_N-1:0] tap;
	} stp_presc_s;
	typedef struct packed {
		logic s1;
		logic s2;
	} stp_sync_s;
endpackage

// *** design/stp_pin_sync.sv ***
// Count pin sampler: a clock-high latch, two flops and an edge detector.
// Assumes the pin is asynchronous to ref_clk and slower than ref_clk / 2.
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_pin_sync (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic countPin,
	output logic pinLevel,
	output logic riseTick,
	output logic fallTick
);
	logic latched;
	stp_pkg::stp_sync_s r, n;

	// The latch is the first sampling stage and only the first flop reads it.
	always_latch begin
		if (ref_clk) begin
			latched = countPin;
		end
	end

	always_comb begin
		n = r;
		n.s1 = latched;
		n.s2 = r.s1;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// The edge detector trusts the pin to hold each level over a clock period.
	assign pinLevel = r.s2;
	assign riseTick = r.s1 && !r.s2;
	assign fallTick = !r.s1 && r.s2;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_rise_single;
		riseTick |=> !riseTick && pinLevel;
	endproperty
	a_rise_single: assert property (p_rise_single) else $error("rise tick not single");

	property p_fall_single;
		fallTick |=> !fallTick && !pinLevel;
	endproperty
	a_fall_single: assert property (p_fall_single) else $error("fall tick not single");
endmodule // stp_pin_sync

// *** design/stp_prescale_counter.sv ***
// Free running ten bit prescaler with four registered tap pulses.
// Assumes holdReset is a registered level from the same clock domain.
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_prescale_counter (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic holdReset,
	output logic [`STP_CNT_W-1:0] count,
	output logic [`STP_TAP_N-1:0] tap
);
	stp_pkg::stp_presc_s r, n;

	function automatic logic ones_low(input logic [`STP_CNT_W-1:0] c, input int bits);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < bits; i++) begin
			hit = hit & c[i];
		end
		return hit;
	endfunction

	always_comb begin
		n = r;
		if (holdReset) begin
			n.count = '0;
			n.tap = '0;
		end else begin
			n.count = r.count + 1'b1;
			n.tap[0] = ones_low(r.count, `STP_TAP0_BITS);
			n.tap[1] = ones_low(r.count, `STP_TAP1_BITS);
			n.tap[2] = ones_low(r.count, `STP_TAP2_BITS);
			n.tap[3] = ones_low(r.count, `STP_TAP3_BITS);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign count = r.count;
	assign tap = r.tap;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_hold_zero;
		holdReset |=> count == '0 && tap == '0;
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("prescaler not held");

	property p_count_runs;
		!holdReset |=> count == $past(count) + 1'b1;
	endproperty
	a_count_runs: assert property (p_count_runs) else $error("prescaler stalled");

	property p_tap8_period;
		(tap[0] && !holdReset) ##1 (!holdReset)[*7] |=> tap[0];
	endproperty
	a_tap8_period: assert property (p_tap8_period) else $error("divide by 8 tap off");
endmodule // stp_prescale_counter

// *** testbench/stp_tick_counter_model.sv ***
// Model of the two timer units that consume the tick enables.
// Assumes ticks are one-cycle enables registered on ref_clk.
`timescale 1ns/1ps
module stp_tick_counter_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clearCounts,
	input wire logic timerATick,
	input wire logic timerBTick,
	output logic [15:0] countA,
	output logic [15:0] countB
);
	// A level held high counts once per cycle, so a stretched pulse shows as extra counts.
	always_ff @(posedge ref_clk) begin
		if (!resetn || clearCounts) begin
			countA <= 16'h0;
			countB <= 16'h0;
		end else begin
			countA <= countA + {15'h0, timerATick};
			countB <= countB + {15'h0, timerBTick};
		end
	end
endmodule // stp_tick_counter_model

// *** testbench/stp_timer_prescaler_tb_top.sv ***
// Bench for the timer prescaler: registers, select rows, count pins and hold mode.
// Assumes the design files and the tick counter model are compiled first.
`timescale 1ns/1ps
`include "stp_consts.svh"
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errors++; \
	$display("wrong value at %0t: got %0h want %0h", $time, got, exp); end end
module stp_timer_prescaler_tb_top;
	typedef struct packed {
		logic [2:0] selA;
		logic [2:0] selB;
		logic [15:0] expA;
		logic [15:0] expB;
	} stp_row_s;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic countPinA = 1'b0;
	logic countPinB = 1'b0;
	logic clearCounts = 1'b0;
	logic hreadyout;
	logic hresp;
	logic timerATick;
	logic timerBTick;
	logic asyncPrescalerReset;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [31:0] rd2;
	logic [15:0] countA;
	logic [15:0] countB;
	int errors = 0;
	int samplesChecked = 0;
	logic [5:0] offs [4] = '{`STP_OFS_GTC, `STP_OFS_SELA, `STP_OFS_SELB, 6'h10};
	// A window of k*N cycles holds exactly k pulses of period N, whatever the phase.
	stp_row_s rows [6] = '{'{3'h1, 3'h0, 16'h0800, 16'h0000}, '{3'h2, 3'h3, 16'h0100, 16'h0020},
		'{3'h4, 3'h5, 16'h0008, 16'h0002}, '{3'h5, 3'h4, 16'h0002, 16'h0008},
		'{3'h3, 3'h2, 16'h0020, 16'h0100}, '{3'h0, 3'h0, 16'h0000, 16'h0000}};

	always #12.5 ref_clk = ~ref_clk;

	stp_timer_prescaler dut_u (
		.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .countPinA(countPinA),
		.countPinB(countPinB), .timerATick(timerATick), .timerBTick(timerBTick),
		.asyncPrescalerReset(asyncPrescalerReset)
	);
	stp_tick_counter_model model_u (
		.ref_clk(ref_clk), .resetn(resetn), .clearCounts(clearCounts),
		.timerATick(timerATick), .timerBTick(timerBTick), .countA(countA), .countB(countB)
	);

	task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		logic rdy;
		hsel <= 1'b1;
		haddr <= {26'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do begin
			@(negedge ref_clk);
			rdy = hreadyout;
			@(posedge ref_clk);
		end while (rdy !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin
			@(negedge ref_clk);
			rdy = hreadyout;
			rdat = hrdata;
			@(posedge ref_clk);
		end while (rdy !== 1'b1);
		`CHK(hresp, 1'b0)
	endtask

	task automatic window(input int n, input logic [15:0] ea, input logic [15:0] eb);
		@(posedge ref_clk);
		clearCounts <= 1'b1;
		@(posedge ref_clk);
		clearCounts <= 1'b0;
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK(countA, ea)
		`CHK(countB, eb)
		@(posedge ref_clk);
	endtask

	task automatic testDone;
		$display("comparisons %0d, mismatches %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#1000000;
		errors++;
		testDone();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		xfer(1'b1, 6'h10, 32'hffffffff, rd);
		foreach (offs[i]) begin
			xfer(1'b0, offs[i], 32'h0, rd);
			`CHK(rd, 32'h0)
		end
		foreach (rows[i]) begin
			xfer(1'b1, `STP_OFS_SELA, {29'h0, rows[i].selA}, rd);
			xfer(1'b1, `STP_OFS_SELB, {29'h0, rows[i].selB}, rd);
			xfer(1'b0, `STP_OFS_SELB, 32'h0, rd);
			`CHK(rd, {29'h0, rows[i].selB})
			window(2048, rows[i].expA, rows[i].expB);
		end
		xfer(1'b0, `STP_OFS_STAT, 32'h0, rd);
		xfer(1'b0, `STP_OFS_STAT, 32'h0, rd2);
		`CHK(rd2[9:0] - rd[9:0], 10'h2)
		// Pins stay steady around each select change and toggle at one sixth of the clock.
		xfer(1'b1, `STP_OFS_SELA, 32'h7, rd);
		xfer(1'b1, `STP_OFS_SELB, 32'h6, rd);
		fork
			window(66, 16'h000a, 16'h000a);
			begin
				repeat (2) @(posedge ref_clk);
				repeat (10) begin
					countPinA <= 1'b1;
					countPinB <= 1'b1;
					repeat (3) @(posedge ref_clk);
					countPinA <= 1'b0;
					countPinB <= 1'b0;
					repeat (3) @(posedge ref_clk);
				end
			end
		join
		xfer(1'b1, `STP_OFS_SELA, 32'h1, rd);
		xfer(1'b1, `STP_OFS_SELB, 32'h2, rd);
		xfer(1'b1, `STP_OFS_GTC, 32'h83, rd);
		xfer(1'b0, `STP_OFS_GTC, 32'h0, rd);
		`CHK(rd, 32'h83)
		`CHK(asyncPrescalerReset, 1'b1)
		window(40, 16'h0, 16'h0);
		xfer(1'b0, `STP_OFS_STAT, 32'h0, rd);
		`CHK(rd[9:0], 10'h0)
		xfer(1'b1, `STP_OFS_GTC, 32'h0, rd);
		xfer(1'b0, `STP_OFS_GTC, 32'h0, rd);
		`CHK(rd, 32'h0)
		`CHK(asyncPrescalerReset, 1'b0)
		window(64, 16'h0040, 16'h0008);
		xfer(1'b1, `STP_OFS_GTC, 32'h1, rd);
		xfer(1'b0, `STP_OFS_GTC, 32'h0, rd);
		`CHK(rd, 32'h0)
		xfer(1'b0, `STP_OFS_STAT, 32'h0, rd);
		`CHK(rd[9:0], 10'h1)
		countPinA <= 1'b1;
		repeat (3) @(posedge ref_clk);
		xfer(1'b0, `STP_OFS_STAT, 32'h0, rd);
		`CHK(rd[`STP_STAT_PINB:`STP_STAT_PINA], 2'h1)
		testDone();
	end
endmodule // stp_timer_prescaler_tb_top
